/* inc/cmoi_pkg.sv */
package cmoi_pkg;
    // What this block does
    // RULE1: Direction bit picks object write or read-back
    // RULE2: Filter, header, control selects gate their fields
    // RULE3: Transfer may clear irq_pending and fresh_payload
    // RULE4: Low/high payload selects move four bytes each
    // RULE5: Low filter word covers extended bits 15..0
    // RULE6: High filter word covers 28..16, or 10..0
    // RULE7: All-zero filter passes every message
    // RULE8: Extended and direction flags compared when enabled
    // RULE9: Filter used only with filter_use_en, else exact
    // RULE10: Extended tag split low/high, long_id_flag set
    // RULE11: Standard tag in high word bits 12..2
    // RULE12: sent_irq_en sets irq_pending after sending
    // RULE13: Remote frame match sets send_request if enabled
    // RULE14: payload_len sets byte count; fifo_last for singles
    // RULE15: Software leaves status bits clear when configuring
    // RULE16: Byte 0 sits in low byte of payload A1
    // RULE17: Object number write starts the transfer
    // RULE18: Valid object with send_request becomes eligible
    // RULE19: Payload updates accepted at any time
    // RULE20: Software makes all data bytes valid first
    // RULE21: Fresh data keeps send_request; cleared at start
    // RULE22: Scan from object 1, first match wins
    // RULE23: Lowest pending object number sends first
    // RULE24: Filter one compares bit, zero ignores it

    localparam int unsigned OBJ_N  = 32;          // Message objects
    localparam int unsigned WORD_N = 9;           // Words per object
    localparam logic [5:0]  OBJ_LAST = 6'h20;     // Highest object number
    localparam logic [5:0]  OBJ_FIRST = 6'h01;

    // Byte addresses on the register bus
    localparam logic [7:0] A_CRQ     = 8'h00;
    localparam logic [7:0] A_CMASK   = 8'h04;
    localparam logic [7:0] A_IF_BASE = 8'h08;     // First interface word
    localparam logic [7:0] A_IF_LAST = 8'h28;     // Last interface word
    localparam logic [7:0] A_STAT    = 8'h2c;

    // Word positions inside an object and the interface set
    localparam int unsigned K_FLO = 0;
    localparam int unsigned K_FHI = 1;
    localparam int unsigned K_HLO = 2;
    localparam int unsigned K_HHI = 3;
    localparam int unsigned K_CTL = 4;
    localparam int unsigned K_PA1 = 5;
    localparam int unsigned K_PA2 = 6;
    localparam int unsigned K_PB1 = 7;
    localparam int unsigned K_PB2 = 8;

    // if_command_mask bits
    localparam int unsigned CM_WR   = 7;
    localparam int unsigned CM_FILT = 6;
    localparam int unsigned CM_HDR  = 5;
    localparam int unsigned CM_CTL  = 4;
    localparam int unsigned CM_IRQC = 3;
    localparam int unsigned CM_NEW  = 2;
    localparam int unsigned CM_LO   = 1;
    localparam int unsigned CM_HI   = 0;

    // if_filter_high and if_header_high bits
    localparam int unsigned FH_MX   = 15;
    localparam int unsigned FH_MD   = 14;
    localparam int unsigned HH_VAL  = 15;
    localparam int unsigned HH_EXT  = 14;
    localparam int unsigned HH_DIR  = 13;
    localparam int unsigned TAG_TOP = 12;
    localparam int unsigned STD_LSB = 2;

    // if_object_control bits
    localparam int unsigned OC_NEW  = 15;
    localparam int unsigned OC_OVR  = 14;
    localparam int unsigned OC_IRQ  = 13;
    localparam int unsigned OC_USE  = 12;
    localparam int unsigned OC_SENT_IRQ_EN = 11;
    localparam int unsigned OC_RMT  = 9;
    localparam int unsigned OC_TXR  = 8;
    localparam int unsigned OC_EOB  = 7;
    localparam int unsigned LEN_TOP = 3;

    localparam logic [28:0] ID_EXT_ALL = 29'h1fffffff;
    localparam logic [28:0] ID_STD_ALL = 29'h000007ff;
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [7:0]  RST_CMASK  = 8'h00;
endpackage

/* rtl/cmoi_top.sv */
module cmoi_top
    import cmoi_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        rx_hdr_valid_i,
    input  wire logic [28:0] rx_id_i,
    input  wire logic        rx_ext_i,
    input  wire logic        rx_remote_i,
    output logic             match_valid_o,
    output logic             match_found_o,
    output logic      [5:0]  match_obj_o,
    input  wire logic        tx_load_i,
    input  wire logic        tx_done_i,
    output logic             tx_pending_o,
    output logic      [5:0]  tx_obj_o,
    output logic      [28:0] tx_id_o,
    output logic             tx_ext_o,
    output logic      [3:0]  tx_len_o,
    output logic      [63:0] tx_data_o
);

    logic        pready_q,  pready_d;
    logic        pslverr_q, pslverr_d;
    logic [31:0] prdata_q,  prdata_d;
    logic        acc;
    logic        wr_en;
    logic        hit_if;
    logic [3:0]  if_k;
    logic        cmd_fire;
    logic [4:0]  cidx;
    logic [4:0]  cidx_q;
    logic [5:0]  crq_q,   crq_d;
    logic [7:0]  cmask_q, cmask_d;
    logic [15:0] ifr_q [WORD_N];
    logic [15:0] ifr_d [WORD_N];
    logic [15:0] obj_q [OBJ_N][WORD_N];
    logic [15:0] obj_d [OBJ_N][WORD_N];
    logic [OBJ_N-1:0] match_v;
    logic [OBJ_N-1:0] pend_v;
    logic [28:0] oid_v [OBJ_N];
    logic        m_found, p_found;
    logic [4:0]  m_idx,   p_idx;
    logic        match_valid_q, match_valid_d;
    logic        match_found_q, match_found_d;
    logic [5:0]  match_obj_q,   match_obj_d;
    logic        tx_pending_q,  tx_pending_d;
    logic [5:0]  tx_obj_q,      tx_obj_d;
    logic [28:0] tx_id_q,       tx_id_d;
    logic        tx_ext_q,      tx_ext_d;
    logic [3:0]  tx_len_q,      tx_len_d;
    logic [63:0] tx_data_q,     tx_data_d;
    logic        tx_active_q,   tx_active_d;
    logic [5:0]  tx_cur_q,      tx_cur_d;
    logic [4:0]  tidx, aidx;

    // Which command-mask select governs interface word k
    function automatic logic word_sel(input int unsigned k,
                                      input logic [7:0]  m);
        if (k <= K_FHI) return m[CM_FILT];
        else if (k <= K_HHI) return m[CM_HDR];
        else if (k == K_CTL) return m[CM_CTL];
        else if (k <= K_PA2) return m[CM_LO];
        else return m[CM_HI];
    endfunction

    // Bus decode; a write lands on the edge that ends the access phase
    always_comb begin
        acc      = psel_i && penable_i;
        wr_en    = acc && pready_q && pwrite_i;
        hit_if   = paddr_i >= A_IF_BASE && paddr_i <= A_IF_LAST
                   && paddr_i[1:0] == 2'b00;
        if_k     = 4'((paddr_i - A_IF_BASE) >> 2);
        cidx     = 5'(pwdata_i[5:0] - OBJ_FIRST);
        cmd_fire = wr_en && paddr_i == A_CRQ                     // RULE17
                   && pwdata_i[5:0] >= OBJ_FIRST
                   && pwdata_i[5:0] <= OBJ_LAST;
        tidx     = 5'(tx_obj_q - OBJ_FIRST);
        aidx     = 5'(tx_cur_q - OBJ_FIRST);
    end

    // One wait state keeps read data registered without a bypass path
    always_comb begin
        pready_d  = acc && !pready_q;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;
        if (acc && !pready_q) begin
            prdata_d = 32'h0000_0000;
            if (paddr_i == A_CRQ)
                prdata_d = {26'h0, crq_q};
            else if (paddr_i == A_CMASK)
                prdata_d = {24'h0, cmask_q};
            else if (hit_if)
                prdata_d = {16'h0000, ifr_q[if_k]};
            else if (paddr_i == A_STAT)
                prdata_d = {18'h0, tx_pending_q, tx_obj_q,
                            match_found_q, match_obj_q};
            else
                pslverr_d = 1'b1;  // Unmapped: error, data zero
        end
    end

    // Interface register set, loaded by software or by a read-back
    always_comb begin
        crq_d   = crq_q;
        cmask_d = cmask_q;
        ifr_d   = ifr_q;
        if (wr_en && paddr_i == A_CRQ)
            crq_d = pwdata_i[5:0];
        if (wr_en && paddr_i == A_CMASK)
            cmask_d = pwdata_i[7:0];
        if (wr_en && hit_if)
            ifr_d[if_k] = pwdata_i[15:0];
        if (cmd_fire && !cmask_q[CM_WR]) begin                   // RULE1
            for (int unsigned k = 0; k < WORD_N; k++) begin
                if (word_sel(k, cmask_q))                   // RULE2 RULE4
                    ifr_d[k] = obj_q[cidx][k];
            end
        end
    end

    // Per-object acceptance compare and transmit eligibility
    for (genvar i = 0; i < OBJ_N; i++) begin : g_obj
        logic [15:0] fl, fh, hh, ct;
        logic        ext_o, use_m, mx, md;
        logic [28:0] msk;
        assign fl    = obj_q[i][K_FLO];
        assign fh    = obj_q[i][K_FHI];
        assign hh    = obj_q[i][K_HHI];
        assign ct    = obj_q[i][K_CTL];
        assign ext_o = hh[HH_EXT];
        assign use_m = ct[OC_USE];
        // Tag position depends on the identifier length
        assign oid_v[i] = ext_o ? {hh[TAG_TOP:0], obj_q[i][K_HLO]}  // RULE10
                        : {18'h0, hh[TAG_TOP:STD_LSB]};             // RULE11
        // Without the filter every tag bit must match
        assign msk = !use_m ? (ext_o ? ID_EXT_ALL : ID_STD_ALL)     // RULE9
                   : ext_o ? {fh[TAG_TOP:0], fl}              // RULE5 RULE6
                   : {18'h0, fh[TAG_TOP:STD_LSB]};                  // RULE6
        assign mx = use_m ? fh[FH_MX] : 1'b1;                       // RULE8
        assign md = use_m ? fh[FH_MD] : 1'b1;                       // RULE8
        // Zero filter bits drop out of the compare entirely
        assign match_v[i] = hh[HH_VAL]                        // RULE7 RULE24
                            && ((rx_id_i ^ oid_v[i]) & msk) == '0
                            && (!mx || ext_o == rx_ext_i)
                            && (!md || hh[HH_DIR] == rx_remote_i);
        assign pend_v[i] = hh[HH_VAL] && ct[OC_TXR];               // RULE18
    end

    // Lowest object number wins both the scan and the arbitration
    always_comb begin
        m_found = 1'b0;
        m_idx   = '0;
        p_found = 1'b0;
        p_idx   = '0;
        for (int j = OBJ_N - 1; j >= 0; j--) begin
            if (match_v[j]) begin                                  // RULE22
                m_found = 1'b1;
                m_idx   = 5'(j);
            end
            if (pend_v[j]) begin                                   // RULE23
                p_found = 1'b1;
                p_idx   = 5'(j);
            end
        end
    end

    // Message store: the load clear goes first, so that fresh data written
    // at the very edge of a load survives; link-side sets go last so they win
    always_comb begin
        obj_d = obj_q;
        if (tx_load_i && tx_pending_q)                           // RULE21
            obj_d[tidx][K_CTL][OC_NEW] = 1'b0;
        if (cmd_fire) begin
            if (cmask_q[CM_WR]) begin                   // RULE1 RULE19
                for (int unsigned k = 0; k < WORD_N; k++) begin
                    if (word_sel(k, cmask_q))           // RULE2 RULE4
                        obj_d[cidx][k] = ifr_q[k];
                end
            end else begin
                if (cmask_q[CM_IRQC])                             // RULE3
                    obj_d[cidx][K_CTL][OC_IRQ] = 1'b0;
                if (cmask_q[CM_NEW])                              // RULE3
                    obj_d[cidx][K_CTL][OC_NEW] = 1'b0;
            end
        end
        if (tx_done_i && tx_active_q) begin
            // New data since the start means this frame was stale
            if (!obj_d[aidx][K_CTL][OC_NEW])                     // RULE21
                obj_d[aidx][K_CTL][OC_TXR] = 1'b0;
            if (obj_q[aidx][K_CTL][OC_SENT_IRQ_EN])                     // RULE12
                obj_d[aidx][K_CTL][OC_IRQ] = 1'b1;
        end
        if (rx_hdr_valid_i && rx_remote_i && m_found
            && obj_q[m_idx][K_CTL][OC_RMT])                      // RULE13
            obj_d[m_idx][K_CTL][OC_TXR] = 1'b1;
    end

    // Link-side results and the transmit candidate
    always_comb begin
        match_valid_d = rx_hdr_valid_i;
        match_found_d = match_found_q;
        match_obj_d   = match_obj_q;
        if (rx_hdr_valid_i) begin                                // RULE22
            match_found_d = m_found;
            match_obj_d   = m_found ? 6'(m_idx) + OBJ_FIRST : 6'h00;
        end
        // Held off while a transfer touches the store
        tx_pending_d = p_found && !cmd_fire;
        tx_obj_d     = p_found ? 6'(p_idx) + OBJ_FIRST : 6'h00;
        tx_id_d      = oid_v[p_idx];
        tx_ext_d     = obj_q[p_idx][K_HHI][HH_EXT];
        tx_len_d     = obj_q[p_idx][K_CTL][LEN_TOP:0];           // RULE14
        tx_data_d    = {obj_q[p_idx][K_PB2], obj_q[p_idx][K_PB1],
                        obj_q[p_idx][K_PA2], obj_q[p_idx][K_PA1]}; // RULE16
        tx_active_d  = tx_active_q;
        tx_cur_d     = tx_cur_q;
        if (tx_load_i && tx_pending_q) begin
            tx_active_d = 1'b1;
            tx_cur_d    = tx_obj_q;
        end else if (tx_done_i) begin
            tx_active_d = 1'b0;
        end
    end

    // All state registers; fifo_last and overrun are stored only
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pready_q      <= 1'b0;
            pslverr_q     <= 1'b0;
            prdata_q      <= '0;
            crq_q         <= '0;
            cmask_q       <= RST_CMASK;
            cidx_q        <= '0;
            for (int unsigned k = 0; k < WORD_N; k++) begin
                ifr_q[k] <= RST_WORD;
                for (int unsigned n = 0; n < OBJ_N; n++) begin
                    obj_q[n][k] <= RST_WORD;
                end
            end
            match_valid_q <= 1'b0;
            match_found_q <= 1'b0;
            match_obj_q   <= '0;
            tx_pending_q  <= 1'b0;
            tx_obj_q      <= '0;
            tx_id_q       <= '0;
            tx_ext_q      <= 1'b0;
            tx_len_q      <= '0;
            tx_data_q     <= '0;
            tx_active_q   <= 1'b0;
            tx_cur_q      <= '0;
        end else begin
            pready_q      <= pready_d;
            pslverr_q     <= pslverr_d;
            prdata_q      <= prdata_d;
            crq_q         <= crq_d;
            cmask_q       <= cmask_d;
            cidx_q        <= cidx;
            ifr_q         <= ifr_d;
            obj_q         <= obj_d;
            match_valid_q <= match_valid_d;
            match_found_q <= match_found_d;
            match_obj_q   <= match_obj_d;
            tx_pending_q  <= tx_pending_d;
            tx_obj_q      <= tx_obj_d;
            tx_id_q       <= tx_id_d;
            tx_ext_q      <= tx_ext_d;
            tx_len_q      <= tx_len_d;
            tx_data_q     <= tx_data_d;
            tx_active_q   <= tx_active_d;
            tx_cur_q      <= tx_cur_d;
        end
    end

    assign prdata_o      = prdata_q;
    assign pready_o      = pready_q;
    assign pslverr_o     = pslverr_q;
    assign match_valid_o = match_valid_q;
    assign match_found_o = match_found_q;
    assign match_obj_o   = match_obj_q;
    assign tx_pending_o  = tx_pending_q;
    assign tx_obj_o      = tx_obj_q;
    assign tx_id_o       = tx_id_q;
    assign tx_ext_o      = tx_ext_q;
    assign tx_len_o      = tx_len_q;
    assign tx_data_o     = tx_data_q;

    // Checks on the transfer, filter and transmit paths
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    pay_write_a: assert property (cmd_fire && cmask_q[CM_WR] // RULE4
        && cmask_q[CM_LO] |=> obj_q[cidx_q][K_PA1] == $past(ifr_q[K_PA1]))
        else $error("payload A1 not written to object");
    hdr_keep_a: assert property (cmd_fire && cmask_q[CM_WR] // RULE2
        && !cmask_q[CM_HDR]
        |=> obj_q[cidx_q][K_HHI] == $past(obj_q[cidx][K_HHI]))
        else $error("header changed without header select");
    filt_read_a: assert property (cmd_fire && !cmask_q[CM_WR] // RULE1
        && cmask_q[CM_FILT] |=> ifr_q[K_FLO] == obj_q[cidx_q][K_FLO])
        else $error("filter word not read back");
    irq_clear_a: assert property (cmd_fire && !cmask_q[CM_WR] // RULE3
        && cmask_q[CM_IRQC] && !tx_done_i
        |=> !obj_q[cidx_q][K_CTL][OC_IRQ])
        else $error("irq_pending not cleared");
    match_first_a: assert property (rx_hdr_valid_i && match_v[0] // RULE22
        |=> match_valid_o && match_found_o && match_obj_o == OBJ_FIRST)
        else $error("object 1 match not reported first");
    sent_irq_a: assert property (tx_done_i && tx_active_q // RULE12
        && obj_q[aidx][K_CTL][OC_SENT_IRQ_EN]
        |=> obj_q[$past(aidx)][K_CTL][OC_IRQ])
        else $error("irq_pending not set after sending");
    keep_txr_a: assert property (tx_done_i && tx_active_q // RULE21
        && obj_q[aidx][K_CTL][OC_NEW] && !cmd_fire
        |=> obj_q[$past(aidx)][K_CTL][OC_TXR])
        else $error("send_request cleared despite fresh data");
    auto_reply_a: assert property (rx_hdr_valid_i && rx_remote_i // RULE13
        && m_found && obj_q[m_idx][K_CTL][OC_RMT]
        |=> obj_q[$past(m_idx)][K_CTL][OC_TXR] ##1 tx_pending_o)
        else $error("remote frame did not request sending");
    tx_prio_a: assert property (pend_v[0] && !cmd_fire // RULE23
        |=> tx_pending_o && tx_obj_o == OBJ_FIRST)
        else $error("object 1 not chosen first");
    bus_wait_a: assert property (psel_i && penable_i && !pready_o
        |=> pready_o ##1 !pready_o)
        else $error("bus answer not one wait state");
    fresh_clear_a: assert property (tx_load_i && tx_pending_q // RULE21
        && !(cmd_fire && cmask_q[CM_WR] && cidx == tidx)
        |=> !obj_q[$past(tidx)][K_CTL][OC_NEW])
        else $error("fresh_payload not cleared at load");

    write_cmd_c: cover property (cmd_fire && cmask_q[CM_WR]);
    sent_c:      cover property (tx_done_i && tx_active_q);
    remote_c:    cover property (rx_hdr_valid_i && rx_remote_i && m_found);
    reload_c:    cover property (tx_done_i && tx_active_q
        && obj_q[aidx][K_CTL][OC_NEW]);
endmodule

/* test/cmoi_bus_model.sv */
module cmoi_bus_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic [7:0]  dly_i,
    input  wire logic        tx_pending_i,
    input  wire logic [5:0]  tx_obj_i,
    output logic             tx_load_o,
    output logic             tx_done_o,
    output logic      [7:0]  cnt_o,
    output logic      [11:0] seq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       busy_q;
    logic [7:0] t_q;

    // Shifter: sends for dly_i cycles, then rests four cycles so the
    // store has retired the request before a stale offer is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {busy_q, t_q, tx_load_o, tx_done_o, cnt_o, seq_o} <= '0;
        end else begin
            tx_load_o <= 1'b0;
            tx_done_o <= 1'b0;
            if (t_q != 8'h00) begin
                t_q <= t_q - 8'h01;
            end else if (busy_q) begin
                tx_done_o <= 1'b1;
                busy_q    <= 1'b0;
                cnt_o     <= cnt_o + 8'h01;
                t_q       <= 8'h04;
            end else if (go_i && tx_pending_i) begin
                tx_load_o <= 1'b1;
                busy_q    <= 1'b1;
                t_q       <= dly_i;
                seq_o     <= {seq_o[5:0], tx_obj_i}; // Order log
            end
        end
    end
endmodule

/* test/cmoi_bench.sv */
module cmoi_bench
    import cmoi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] D1 = 64'h0807060504030201;
    localparam logic [63:0] D2 = 64'h1817161514131211;
    logic        clk, rst, psel, pen, pwr, pready, pslverr;
    logic [7:0]  paddr, dly, cnt;
    logic [31:0] pwdata, prdata, rdat;
    logic        rxv, rxext, rxrem, mv, mf, rerr, go;
    logic        load, done, pend, text;
    logic [28:0] rxid, tid;
    logic [5:0]  mobj, tobj;
    logic [3:0]  tlen;
    logic [63:0] tdata;
    logic [11:0] seq;
    int          fail_count, n_compared;

    cmoi_top dut_u (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .rx_hdr_valid_i(rxv), .rx_id_i(rxid),
        .rx_ext_i(rxext), .rx_remote_i(rxrem), .match_valid_o(mv),
        .match_found_o(mf), .match_obj_o(mobj), .tx_load_i(load),
        .tx_done_i(done), .tx_pending_o(pend), .tx_obj_o(tobj),
        .tx_id_o(tid), .tx_ext_o(text), .tx_len_o(tlen),
        .tx_data_o(tdata));
    cmoi_bus_model model_u (.clk_i(clk), .rst_i(rst), .go_i(go),
        .dly_i(dly), .tx_pending_i(pend), .tx_obj_i(tobj),
        .tx_load_o(load), .tx_done_o(done), .cnt_o(cnt), .seq_o(seq));

    // Free-running 10 MHz clock
    always #50 clk = ~clk;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        {psel, pen} <= 2'b00;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk({32'h0, rdat}, {32'h0, exp});
    endtask

    // Command mask, then object number: starts the transfer
    task automatic xfer(input logic [7:0] m, input logic [5:0] n);
        wr(A_CMASK, {8'h00, m});
        wr(A_CRQ, {10'h000, n});
    endtask

    // Whole-object write; status bits left clear by the caller
    task automatic cfg(input logic [5:0] n,
                       input logic [15:0] flo, fhi, hlo, hhi, ctl,
                       input logic [63:0] d);
        int k;
        wr(A_IF_BASE, flo);
        wr(8'h0c, fhi);
        wr(8'h10, hlo);
        wr(8'h14, hhi);
        wr(8'h18, ctl);
        for (k = 0; k < 4; k++) begin
            wr(8'h1c + 8'(4 * k), d[16 * k +: 16]);
        end
        xfer(8'hf3, n);
    endtask

    // Header pulse, then the scan result one cycle later
    task automatic rx(input logic [28:0] id, input logic e, r,
                      input logic [5:0] exp);
        @(posedge clk);
        {rxv, rxid, rxext, rxrem} <= {1'b1, id, e, r};
        @(posedge clk);
        rxv <= 1'b0;
        @(posedge clk);
        chk({mv, mf, mobj}, {1'b1, exp != 6'h00, exp});
    endtask

    // Bounded wait for the shifter to finish c frames in all
    task automatic waitc(input logic [7:0] c);
        int n;
        n = 0;
        while (cnt !== c && n < 3000) begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
        chk(cnt, c);
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report;
    end

    // Main sequence
    initial begin
        {clk, psel, pen, pwr, paddr, pwdata, rxv, rxid, rxext} = '0;
        {rxrem, go, fail_count, n_compared} = '0;
        dly = 8'h03;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(A_STAT, 32'h0);
        apb(1'b0, 8'h30, 32'h1);
        chk({rerr, rdat}, {1'b1, 32'h0});
        // Object 2 pending first, object 1 must still win
        cfg(6'd2, 16'h0, 16'h0, 16'h0, 16'ha48c, 16'h0284, D2);
        cfg(6'd1, 16'h0, 16'h0, 16'h0, 16'hb158, 16'h0888, D1);
        wr(8'h18, 16'h0384);
        xfer(8'h90, 6'd2);
        wr(8'h18, 16'h0988);
        xfer(8'h90, 6'd1);
        repeat (3) @(posedge clk);
        chk({pend, tobj, tid, text, tlen},
            {1'b1, 6'd1, 29'h456, 1'b0, 4'h8});
        chk(tdata, D1);
        rd(A_STAT, 32'h2080);
        go <= 1'b1;
        waitc(8'd2);
        chk({pend, seq}, {1'b0, 12'h042});
        xfer(8'h10, 6'd1);
        rd(8'h18, 32'h2888);
        xfer(8'h10, 6'd2);
        rd(8'h18, 32'h0284);
        xfer(8'h08, 6'd1);
        xfer(8'h10, 6'd1);
        rd(8'h18, 32'h0888);
        // Header and low payload only; the rest must not move
        xfer(8'h22, 6'd2);
        rd(8'h14, 32'ha48c);
        rd(8'h1c, {16'h0, D2[15:0]});
        rd(8'h24, {16'h0, D1[47:32]});
        rd(8'h18, 32'h0888);
        // Receive objects: masked extended, exact standard, open
        cfg(6'd4, 16'hfff0, 16'h9fff, 16'h4567, 16'hc123, 16'h1080, 0);
        cfg(6'd5, 16'h0, 16'h0, 16'h0, 16'h8a94, 16'h0080, 0);
        cfg(6'd6, 16'h0, 16'h0, 16'h0, 16'h8000, 16'h1080, 0);
        xfer(8'h40, 6'd4);
        rd(8'h08, 32'hfff0);
        rd(8'h0c, 32'h9fff);
        rx(29'h1234567, 1'b1, 1'b0, 6'd4);
        rx(29'h123456a, 1'b1, 1'b0, 6'd4);
        rx(29'h1234577, 1'b1, 1'b0, 6'd6);
        rx(29'h0234567, 1'b1, 1'b0, 6'd6);
        rx(29'h00002a5, 1'b0, 1'b0, 6'd5);
        rx(29'h00002a4, 1'b0, 1'b0, 6'd6);
        rx(29'h0000456, 1'b0, 1'b1, 6'd1);
        rx(29'h0000123, 1'b0, 1'b1, 6'd2);
        waitc(8'd3);
        chk(seq[5:0], 6'd2);
        // Fresh data with request during a long transmission
        dly <= 8'h1e;
        wr(8'h18, 16'h0988);
        xfer(8'h90, 6'd1);
        repeat (8) @(posedge clk);
        wr(8'h18, 16'h8988);
        xfer(8'h90, 6'd1);
        waitc(8'd5);
        chk(seq, 12'h041);
        xfer(8'h10, 6'd1);
        rd(8'h18, 32'h2888);
        // Fresh flag cleared by a read transfer with the clear select
        wr(8'h18, 16'h8080);
        xfer(8'h90, 6'd5);
        xfer(8'h04, 6'd5);
        xfer(8'h10, 6'd5);
        rd(8'h18, 32'h0080);
        final_report;
    end
endmodule
